// ==== dv/flash_status_write_protect_properties.sv ====
`timescale 1ns/10ps
// Watches the status block on the system clock
module flash_status_write_protect_properties
	import flash_status_pkg::*;
#(
	parameter int STATUS_WRITE_TIME_NS = 100
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic cs_n_in,
	input wire logic protect_pin_n_in,
	input wire logic array_busy_in,
	input wire logic array_done_in,
	input wire logic miso_oe_out,
	input wire flash_status_pkg::flash_status_s status_out,
	input wire logic hard_lock_out,
	input wire logic protect_active_out,
	input wire logic full_clear_allowed_out
);
	localparam int W = (STATUS_WRITE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	int busy_len; // Cycles the busy flag has stood
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	// Length of the current busy stretch
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			busy_len <= 0;
		end else begin
			busy_len <= status_out.write_in_progress ? busy_len + 1 : 0;
		end
	end
	property p_zero; status_out.zero == 2'h0; endproperty
	a_zero: assert property (p_zero) else $error("b6 b5 not zero");
	property p_prot; protect_active_out == (status_out.bp != 3'h0); endproperty
	a_prot: assert property (p_prot) else $error("protect flag wrong");
	property p_clr; full_clear_allowed_out == (status_out.bp == 3'h0); endproperty
	a_clr: assert property (p_clr) else $error("full clear flag wrong");
	property p_enter; (status_out.lock && !protect_pin_n_in) [*4] |-> hard_lock_out; endproperty
	a_enter: assert property (p_enter) else $error("hard lock not entered");
	property p_exit; protect_pin_n_in [*4] |-> !hard_lock_out; endproperty
	a_exit: assert property (p_exit) else $error("hard lock not left");
	property p_arr; array_busy_in |-> status_out.write_in_progress; endproperty
	a_arr: assert property (p_arr) else $error("busy flag low in cycle");
	property p_done; array_done_in |=> !status_out.write_enable_latch; endproperty
	a_done: assert property (p_done) else $error("latch kept after cycle");
	property p_len; $fell(status_out.write_in_progress) && !$past(array_busy_in) |-> busy_len == W + 2
		&& !status_out.write_enable_latch; endproperty
	a_len: assert property (p_len) else $error("write cycle length wrong");
	property p_oe; cs_n_in |-> !miso_oe_out; endproperty
	a_oe: assert property (p_oe) else $error("output driven unselected");
endmodule : flash_status_write_protect_properties

// ==== dv/flash_status_write_protect_tb.sv ====
`timescale 1ns/10ps
// Status writes and reads through the host model
module flash_status_write_protect_tb;
	import flash_status_pkg::*;
	typedef struct packed {
		logic pin; // Protect pin level
		logic latch; // Set latch first
		logic [7:0] data; // Byte written
		logic acc; // Timed cycle expected
		logic [7:0] exp; // Status afterwards
	} row_s;
	row_s rows [6] = '{
		'{1'b1, 1'b1, 8'hff, 1'b1, 8'h9c},
		'{1'b1, 1'b0, 8'h00, 1'b0, 8'h9c},
		'{1'b0, 1'b1, 8'h00, 1'b0, 8'h9e},
		'{1'b1, 1'b0, 8'h08, 1'b1, 8'h08},
		'{1'b0, 1'b1, 8'h80, 1'b1, 8'h80},
		'{1'b0, 1'b1, 8'h00, 1'b0, 8'h82}};
	logic sys_clk_in = 1'b0, nrst_in = 1'b0, protect_pin_n_in = 1'b1;
	logic array_busy_in = 1'b0, array_done_in = 1'b0;
	logic spi_clk, cs_n, mosi, miso, miso_oe, miso_line, hard_lock, prot_act, clr_ok;
	flash_status_s status;
	logic [7:0] st, st0, rx, ef;
	int bad_count = 0, checks = 0, cycles = 0;
	assign miso_line = miso_oe ? miso : 1'b1; // Pulled up when released
	always #5 sys_clk_in = ~sys_clk_in;
	flash_status_write_protect #(.STATUS_WRITE_TIME_NS(1000)) dut (.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in), .spi_clk_in(spi_clk), .cs_n_in(cs_n), .mosi_in(mosi),
		.protect_pin_n_in(protect_pin_n_in), .array_busy_in(array_busy_in),
		.array_done_in(array_done_in), .miso_out(miso), .miso_oe_out(miso_oe),
		.status_out(status), .hard_lock_out(hard_lock), .protect_active_out(prot_act),
		.full_clear_allowed_out(clr_ok));
	spi_host_model host (.spi_clk_out(spi_clk), .cs_n_out(cs_n), .mosi_out(mosi),
		.miso_in(miso_line));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	// Frame of opcode and n data bits
	task automatic wr(input logic [7:0] op, input logic [7:0] d, input int n);
		host.begin_frame;
		host.xfer(op, 8, rx);
		host.xfer(d, n, rx);
		host.end_frame;
	endtask : wr
	// Status read that keeps clocking while busy, up to n extra bytes
	task automatic rd(input int n);
		host.begin_frame;
		host.xfer(STATUS_READ_CMD, 8, rx);
		host.xfer(8'h00, 8, st0);
		st = st0;
		for (int k = 0; k < n && st[0]; k++) begin
			host.xfer(8'h00, 8, st);
		end
		host.xfer(8'h00, 8, rx);
		check("repeat", rx, st);
		host.end_frame;
	endtask : rd
	// Hang guard
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (4) @(negedge sys_clk_in);
		nrst_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		rd(0);
		check("power up", st, STATUS_RESET);
		foreach (rows[i]) begin
			@(negedge sys_clk_in);
			protect_pin_n_in = rows[i].pin;
			if (rows[i].latch) begin
				wr(SET_LATCH_CMD, 8'h00, 0);
			end
			wr(STATUS_UPDATE_CMD, rows[i].data, 8);
			rd(40);
			check("busy", {7'h00, st0[0]}, {7'h00, rows[i].acc});
			check("status", st, rows[i].exp);
			ef = {5'h00, ~rows[i].pin & rows[i].exp[7], |rows[i].exp[4:2], ~|rows[i].exp[4:2]};
			check("flags", {5'h00, hard_lock, prot_act, clr_ok}, ef);
		end
		// Data byte cut one bit short
		@(negedge sys_clk_in);
		protect_pin_n_in = 1'b1;
		wr(STATUS_UPDATE_CMD, 8'h00, 7);
		rd(0);
		check("short", st, 8'h82);
		// Clear-latch frame, then set the latch again for the program cycle
		wr(CLEAR_LATCH_CMD, 8'h00, 0);
		rd(0);
		check("clear latch", st, 8'h80);
		wr(SET_LATCH_CMD, 8'h00, 0);
		// Program cycle from the array engine
		@(negedge sys_clk_in);
		array_busy_in = 1'b1;
		rd(0);
		check("array busy", st, 8'h83);
		@(negedge sys_clk_in);
		array_busy_in = 1'b0;
		array_done_in = 1'b1;
		@(negedge sys_clk_in);
		array_done_in = 1'b0;
		rd(0);
		check("array done", st, 8'h80);
		// Set latch, drop it by a cycle end, then a select pulse with no clock
		wr(SET_LATCH_CMD, 8'h00, 0);
		@(negedge sys_clk_in);
		array_done_in = 1'b1;
		@(negedge sys_clk_in);
		array_done_in = 1'b0;
		host.begin_frame;
		host.end_frame;
		rd(0);
		check("empty frame", st, 8'h80);
		@(negedge sys_clk_in);
		nrst_in = 1'b0;
		@(negedge sys_clk_in);
		check("reset", status, STATUS_RESET);
		give_verdict;
	end
endmodule : flash_status_write_protect_tb
bind flash_status_write_protect flash_status_write_protect_properties #(
	.STATUS_WRITE_TIME_NS(STATUS_WRITE_TIME_NS)) chk (.sys_clk_in, .nrst_in, .cs_n_in,
	.protect_pin_n_in, .array_busy_in, .array_done_in, .miso_oe_out, .status_out,
	.hard_lock_out, .protect_active_out, .full_clear_allowed_out);

// ==== dv/spi_host_model.sv ====
`timescale 1ns/10ps
// Serial host: clock idles low and runs only inside frames
module spi_host_model (
	output logic spi_clk_out, // Serial clock, 15 ns period
	output logic cs_n_out, // Chip select, active low
	output logic mosi_out, // Data to the device
	input wire logic miso_in // Resolved data from the device
);
	// Select starts low and rises once, so select-cleared flops leave unknown
	initial begin
		spi_clk_out = 1'b0;
		cs_n_out = 1'b0;
		mosi_out = 1'b0;
		#1;
		cs_n_out = 1'b1;
	end
	// Select the device a full period before the first rising edge
	task automatic begin_frame;
		cs_n_out = 1'b0;
		#7.5;
	endtask : begin_frame
	// Shift n bits MSB first, taking miso on each rising edge
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			mosi_out = tx[i];
			#7.5;
			spi_clk_out = 1'b1;
			rx[i] = miso_in;
			#7.5;
			spi_clk_out = 1'b0;
		end
	endtask : xfer
	// Deselect, let the data line wander, leave a gap
	task automatic end_frame;
		#7.5;
		cs_n_out = 1'b1;
		mosi_out = ~mosi_out;
		#60;
	endtask : end_frame
endmodule : spi_host_model

// ==== hdl/flash_status_write_protect.sv ====
// How it works
// - status read answered even while busy
// - status byte repeats while select stays low
// - busy flag high exactly during internal cycle
// - latch bit readable; clear latch refuses writes
// - protect bits change only by status write
// - full clear allowed only with zero protection
// - status write needs latch set beforehand
// - b6 b5 b1 b0 untouched, b6 b5 zero
// - select must rise after eighth data bit
// - timed cycle, busy held, latch cleared at end
// - lock clear: writes allowed whatever pin level
// - lock set, pin high: writes allowed
// - lock set, pin low: writes rejected
// - hard lock entered in either order
// - hard lock left by pin high, or when an unlocking write accepted before it commits
// - pin held high never hard locks
`timescale 1ns/10ps
module flash_status_write_protect #(
	parameter int STATUS_WRITE_TIME_NS = flash_status_pkg::STATUS_WRITE_TIME_NS
) (
	input wire logic sys_clk_in,                              // System clock, 100 MHz
	input wire logic nrst_in,                                 // Power-up reset, active low
	input wire logic spi_clk_in,                              // Serial clock from the host
	input wire logic cs_n_in,                                 // Chip select, active low
	input wire logic mosi_in,                                 // Serial data input
	input wire logic protect_pin_n_in,                        // Write-protect pin, active low
	input wire logic array_busy_in,                           // Program or erase cycle running
	input wire logic array_done_in,                           // Program or erase cycle ended
	output logic miso_out,                                    // Serial data output
	output logic miso_oe_out,                                 // Output enable for miso
	output flash_status_pkg::flash_status_s status_out,       // Visible status byte
	output logic hard_lock_out,                               // Hardware-protected mode
	output logic protect_active_out,                          // Some region is protected
	output logic full_clear_allowed_out                       // Whole-array clear permitted
);
	import flash_status_pkg::*;

	// Cycle count of the self-timed write, rounded up, never below one
	localparam int WRITE_CYCLES_RAW =
		(STATUS_WRITE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int WRITE_CYCLES = (WRITE_CYCLES_RAW < 1) ? 1 : WRITE_CYCLES_RAW;
	localparam logic [31:0] TIMER_LAST = 32'(WRITE_CYCLES - 1);

	// ---------------- Link domain (serial clock) ----------------

	logic in_frame;           // High after first rising edge of a frame
	frame_s frame;            // Captured opcode, data and counters
	logic [6:0] in_shift;     // Partial byte being assembled
	logic [7:0] status_meta;  // First stage of status synchroniser
	logic [7:0] status_link;  // Status byte as seen by the link
	logic [7:0] out_shift;    // Read-out shift register
	logic drive;              // Output is being driven
	logic frame_tag;          // Flips once at the first edge of every clocked frame
	frame_s next_frame;       // Counters and bytes after this edge
	wire [7:0] full_byte;     // Byte completed by this edge
	wire read_phase;          // Frame is a status read past its opcode
	wire byte_start;          // Falling edge begins a new output byte

	// Byte that finishes when the current bit is sampled
	assign full_byte = {in_shift, mosi_in};

	// Frame start: cleared by select going high, set on first edge
	always_ff @(posedge spi_clk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			in_frame <= 1'b0;
		end else begin
			in_frame <= 1'b1;
		end
	end

	// Frame tag: lets the system side tell a clocked frame from an empty select pulse
	always_ff @(posedge spi_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			frame_tag <= 1'b0;
		end else if (!in_frame) begin
			frame_tag <= ~frame_tag; // First edge of a new frame
		end
	end

	// Counter and byte capture for the next rising edge
	always_comb begin
		next_frame = frame;
		if (!in_frame) begin
			// First bit of a new frame restarts the counters
			next_frame.bit_cnt = 3'h1;
			next_frame.byte_cnt = 2'h0;
		end else begin
			next_frame.bit_cnt = frame.bit_cnt + 3'h1;
			if (frame.bit_cnt == 3'h7) begin
				// Eighth bit of a byte
				if (frame.byte_cnt != BYTES_SAT) begin
					next_frame.byte_cnt = frame.byte_cnt + 2'h1;
				end
				if (frame.byte_cnt == 2'h0) begin
					next_frame.opcode = full_byte;
				end
				if (frame.byte_cnt == ONE_BYTE) begin
					next_frame.data = full_byte;
				end
			end
		end
	end

	// Input bits are sampled on the rising serial edge
	always_ff @(posedge spi_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			in_shift <= 7'h00;
			frame <= '0;
		end else begin
			in_shift <= full_byte[6:0];
			frame <= next_frame;
		end
	end

	// Status byte brought over to the link clock by two flip-flops
	// Bits are synchronised one by one; the write cycle changes them in steps a
	// system cycle apart and a read reloads only at byte starts, so each bit of
	// a byte shows either its value before or after its own change
	always_ff @(posedge spi_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_meta <= STATUS_RESET;
			status_link <= STATUS_RESET;
		end else begin
			status_meta <= status_out;
			status_link <= status_meta;
		end
	end

	// A status read answers whatever the busy state
	assign read_phase = in_frame && (frame.opcode == STATUS_READ_CMD)
		&& (frame.byte_cnt != 2'h0);
	assign byte_start = (frame.bit_cnt == BIT_ZERO);

	// Output bits change on the falling edge; status reloads each byte
	always_ff @(negedge spi_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			out_shift <= STATUS_RESET;
		end else if (read_phase && byte_start) begin
			out_shift <= status_link;
		end else begin
			out_shift <= {out_shift[6:0], 1'b0};
		end
	end

	// Drive enable, dropped at once when select rises
	// Select must rise once after power-up to clear this flop
	always_ff @(negedge spi_clk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			drive <= 1'b0;
		end else if (read_phase) begin
			drive <= 1'b1;
		end
	end

	// Serial output pins
	assign miso_out = out_shift[7];
	assign miso_oe_out = drive;

	// ---------------- System domain ----------------

	logic cs_meta;            // First stage of select synchroniser
	logic cs_sync;            // Synchronised select
	logic cs_prev;            // Previous synchronised select
	logic wp_meta;            // First stage of protect pin synchroniser
	logic wp_sync;            // Synchronised protect pin
	wcycle_e state;           // Status write cycle state
	wcycle_e next_state;      // Next cycle state
	logic [31:0] timer;       // Self-timed cycle counter
	logic lock;               // status_write_lock
	logic [2:0] bp;           // block_protect bits
	logic write_enable_latch;                // write_enable_latch
	logic pend_lock;          // Lock value waiting for commit
	logic [2:0] pend_bp;      // Protect value waiting for commit
	wire frame_end;           // Select just rose
	wire on_boundary;         // Frame ended on a byte boundary
	wire one_byte_frame;      // Exactly one byte shifted
	wire two_byte_frame;      // Exactly two bytes shifted
	wire busy;                // Any internal cycle running
	wire hard_lock;           // Hardware-protected mode
	wire write_ok;            // Status write allowed now
	wire accept_write;        // Status write accepted at frame end
	wire latch_set;           // Latch set at frame end
	wire latch_clear;         // Latch cleared by instruction
	logic seen_tag;           // Tag of the last frame already decoded
	wire fresh_frame;         // Frame end of a frame that had clock edges

	// Select and protect pin pass two flip-flops before use
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_prev <= 1'b1;
			wp_meta <= 1'b1;
			wp_sync <= 1'b1;
		end else begin
			cs_meta <= cs_n_in;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
			wp_meta <= protect_pin_n_in;
			wp_sync <= wp_meta;
		end
	end

	// Remember which frame has been decoded
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			seen_tag <= 1'b0;
		end else if (frame_end) begin
			seen_tag <= frame_tag;
		end
	end

	// Frame captures are still while select is high, so read directly
	assign frame_end = cs_sync && !cs_prev;
	// An empty select pulse leaves the old capture; never decode it twice
	assign fresh_frame = frame_end && (frame_tag != seen_tag);
	assign on_boundary = (frame.bit_cnt == BIT_ZERO);
	assign one_byte_frame = on_boundary && (frame.byte_cnt == ONE_BYTE);
	assign two_byte_frame = on_boundary && (frame.byte_cnt == TWO_BYTES);

	// Busy covers the status write and any array cycle
	assign busy = (state != ST_IDLE) || array_busy_in;

	// Hard lock follows lock and pin, in either order
	assign hard_lock = lock && !wp_sync;

	// Write permission by lock, pin and latch
	assign write_ok = write_enable_latch && !hard_lock && !busy;

	// Only a well-framed status write is taken
	assign accept_write = fresh_frame && two_byte_frame
		&& (frame.opcode == STATUS_UPDATE_CMD) && write_ok;

	// Latch instructions need one whole byte and an idle device
	assign latch_set = fresh_frame && one_byte_frame && !busy
		&& (frame.opcode == SET_LATCH_CMD);
	assign latch_clear = fresh_frame && one_byte_frame && !busy
		&& (frame.opcode == CLEAR_LATCH_CMD);

	// Cycle sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			// Waits for an accepted status write
			ST_IDLE: begin
				if (accept_write) begin
					next_state = ST_TIMING;
				end
			end
			// Counts out the self-timed write
			ST_TIMING: begin
				if (timer == TIMER_LAST) begin
					next_state = ST_COMMIT;
				end
			end
			// Copies the pending bits into the status byte
			ST_COMMIT: begin
				next_state = ST_RELEASE;
			end
			// Clears the latch, then returns to idle
			ST_RELEASE: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Cycle timer runs only while timing
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			timer <= 32'h0;
		end else if (state == ST_TIMING) begin
			timer <= timer + 32'h1;
		end else begin
			// Held at zero outside the timed phase
			timer <= 32'h0;
		end
	end

	// New lock and protect values held until commit
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pend_lock <= LOCK_RESET;
			pend_bp <= BP_RESET;
		end else if (accept_write) begin
			pend_lock <= frame.data[LOCK_POS];
			pend_bp <= frame.data[BP_HI_POS:BP_LO_POS];
		end
	end

	// Non-volatile bits change only at commit
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lock <= LOCK_RESET;
			bp <= BP_RESET;
		end else if (state == ST_COMMIT) begin
			lock <= pend_lock;
			bp <= pend_bp;
		end
	end

	// Write enable latch: cleared after each write cycle ends
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			write_enable_latch <= 1'b0;
		// Any finished cycle or a clear-latch frame drops the latch
		end else if (state == ST_RELEASE || array_done_in || latch_clear) begin
			write_enable_latch <= 1'b0;
		// Set only by a whole set-latch frame on an idle device
		end else if (latch_set) begin
			write_enable_latch <= 1'b1;
		end
	end

	// Visible status byte; b6 and b5 read zero
	assign status_out.lock = lock;
	assign status_out.zero = 2'h0;
	assign status_out.bp = bp;
	assign status_out.write_enable_latch = write_enable_latch;
	assign status_out.write_in_progress = busy;

	// Protection outputs for the array datapath
	assign hard_lock_out = hard_lock;
	assign protect_active_out = |bp;
	assign full_clear_allowed_out = (bp == BP_RESET);

endmodule : flash_status_write_protect

// ==== shared/flash_status_pkg.sv ====
// Shared constants and carriers for the serial flash status and write-protect block
package flash_status_pkg;

	// Instruction codes seen on the serial input
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] STATUS_UPDATE_CMD = 8'h01;
	localparam logic [7:0] SET_LATCH_CMD = 8'h06;
	localparam logic [7:0] CLEAR_LATCH_CMD = 8'h04;

	// Bit positions inside the status byte
	localparam int WIP_POS = 0;
	localparam int WEL_POS = 1;
	localparam int BP_LO_POS = 2;
	localparam int BP_HI_POS = 4;
	localparam int LOCK_POS = 7;

	// Power-up values: delivery state is unlocked and unprotected
	localparam logic [2:0] BP_RESET = 3'h0;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// Byte counter values of a frame (saturates at three)
	localparam logic [1:0] ONE_BYTE = 2'h1;
	localparam logic [1:0] TWO_BYTES = 2'h2;
	localparam logic [1:0] BYTES_SAT = 2'h3;
	localparam logic [2:0] BIT_ZERO = 3'h0;

	// Timing: system clock period and default self-timed status write time
	localparam int SYS_CLK_PERIOD_NS = 10;
	localparam int STATUS_WRITE_TIME_NS = 15000000;

	// Status byte layout, b7 down to b0
	typedef struct packed {
		logic lock;       // status_write_lock, b7
		logic [1:0] zero; // b6 and b5, always zero
		logic [2:0] bp;   // block_protect_hi/mid/lo, b4..b2
		logic write_enable_latch;        // write_enable_latch, b1
		logic write_in_progress;        // write_in_progress, b0
	} flash_status_s;

	// What the link side captured during one frame
	typedef struct packed {
		logic [7:0] opcode;   // first byte
		logic [7:0] data;     // second byte
		logic [2:0] bit_cnt;  // bits into the current byte
		logic [1:0] byte_cnt; // whole bytes seen, saturating
	} frame_s;

	// Self-timed status write cycle
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_TIMING = 4'b0010,
		ST_COMMIT = 4'b0100,
		ST_RELEASE = 4'b1000
	} wcycle_e;

endpackage : flash_status_pkg
